// ===== dv/nec_ctrl_monitor.sv
// nec_ctrl_monitor: port assertions of the command controller.
// assumes binding onto nec_ctrl.
`timescale 1ns/1ps
module nec_ctrl_monitor (
    input wire       clk_i,                  // system clock
    input wire       rst_b_i,                // reset, active low
    input wire       busy_o,                 // busy flag
    input wire       mem_req_o,              // op request
    input wire       mem_done_i,             // op done
    input wire [6:0] mem_op_o,               // op code
    input wire       interface_enabled_o,    // debug path enabled
    input wire       dbg_ready_o,            // debug ready
    input wire       mem_keep_eeprom_o,      // keep eeprom
    input wire       eeprom_preserve_fuse_i, // preserve fuse
    input wire       dbg_rvalid_o,           // load data valid
    input wire [7:0] dbg_rdata_o,            // load data
    input wire [7:0] mem_rdata_i,            // array read byte
    input wire [7:0] mem_wdata_o,            // fuse or lock value
    input wire [7:0] lock_bits_i             // lock bits
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    busy_hold_a: assert property (busy_o && mem_req_o && !mem_done_i |=> busy_o)
        else $error("busy dropped early");
    intf_off_a: assert property (mem_req_o && mem_op_o inside {7'h40, 7'h78}
        |-> !interface_enabled_o) else $error("interface not off");
    busy_block_a: assert property (busy_o |-> !dbg_ready_o)
        else $error("ready while busy");
    keep_ee_a: assert property (mem_req_o && mem_op_o == 7'h40
        |-> mem_keep_eeprom_o == eeprom_preserve_fuse_i) else $error("eeprom keep wrong");
    read_data_a: assert property (mem_req_o && mem_done_i
        && mem_op_o inside {7'h01, 7'h02, 7'h06, 7'h43}
        |=> dbg_rvalid_o && dbg_rdata_o == $past(mem_rdata_i)) else $error("load data lost");
    read_idle_a: assert property (mem_req_o && mem_op_o inside {7'h01, 7'h02, 7'h06, 7'h43}
        |-> !busy_o) else $error("read raised busy");
    lock_gate_a: assert property ($rose(mem_req_o) && lock_bits_i[1:0] == 2'b00
        |-> mem_op_o inside {7'h40, 7'h78}) else $error("op under full lock");
    lock_down_a: assert property (mem_req_o && mem_op_o == 7'h08
        |-> (mem_wdata_o & ~lock_bits_i) == 8'h00) else $error("lock loosened");
    cover property (mem_req_o && mem_op_o == 7'h40);
    cover property (dbg_rvalid_o);
    cover property (busy_o && mem_op_o == 7'h39);
endmodule // nec_ctrl_monitor
bind nec_ctrl nec_ctrl_monitor nec_ctrl_monitor_i (.*);

// ===== dv/nec_mem_model.sv
// nec_mem_model: behavioural memory array behind the command controller.
// answers each op four cycles after the request.
`timescale 1ns/1ps
module nec_mem_model (
    input  wire       clk_i,   // system clock
    input  wire       rst_b_i, // sync reset, active low
    input  wire       req_i,   // op request
    input  wire [6:0] op_i,    // op code
    input  wire [7:0] addr_i,  // low address byte
    input  wire [7:0] wdata_i, // fuse or lock value
    output reg        done_o,  // op finished pulse
    output wire [7:0] rdata_o, // read byte, valid with done only
    output reg  [7:0] lock_o   // lock bits
);
    reg [2:0] cnt;
    // fixed latency; a request still high after done starts a new count
    always @(posedge clk_i) begin
        done_o <= rst_b_i && req_i && !done_o && cnt == 3'h3;
        cnt <= (rst_b_i && req_i && !done_o) ? cnt + 3'h1 : 3'h0;
        if (!rst_b_i) lock_o <= 8'hff;
        else if (done_o && op_i == 7'h40) lock_o <= 8'hff;
        else if (done_o && op_i == 7'h08) lock_o <= wdata_i;
    end
    // inverted when stale so late samples fail
    assign rdata_o = done_o ? addr_i ^ 8'h5a : ~(addr_i ^ 8'h5a);
endmodule // nec_mem_model

// ===== dv/tb_top.sv
// tb_top: directed bench for the command controller.
// assumes the monitor binds itself.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top;
    reg clk_i = 0, rst_b_i = 0, we = 0, re = 0, dwe = 0, dre = 0, fuse = 1;
    reg [2:0] ra = 0;
    reg [7:0] rw = 0, dw = 0;
    reg [23:0] da = 0;
    reg [6:0] bidx = 0;
    integer n_fail = 0, checks_done = 0, k;
    wire rdy, rv, ifen, busy, req, done;
    wire [6:0] op;
    wire [7:0] rdat, drd, mwd, mrd, lock;
    wire [15:0] bdat;
    wire [23:0] maddr;
    localparam [69:0] WRC = {7'h2b, 7'h2e, 7'h2f, 7'h32, 7'h34, 7'h35, 7'h18, 7'h1a, 7'h20, 7'h68};
    localparam [34:0] RDC = {7'h01, 7'h02, 7'h06, 7'h07, 7'h43};
    always #5 clk_i = ~clk_i;
    nec_ctrl nec_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .reg_addr_i(ra),
        .reg_wdata_i(rw), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat), .dbg_addr_i(da),
        .dbg_wdata_i(dw), .dbg_we_i(dwe), .dbg_re_i(dre), .dbg_ready_o(rdy), .dbg_rdata_o(drd),
        .dbg_rvalid_o(rv), .interface_enabled_o(ifen), .busy_o(busy), .eeprom_preserve_fuse_i(fuse),
        .lock_bits_i(lock), .mem_req_o(req), .mem_op_o(op), .mem_addr_o(maddr), .mem_wdata_o(mwd),
        .mem_keep_eeprom_o(), .mem_rdata_i(mrd), .mem_byte_valid_i(1'b0), .mem_byte_i(8'h00),
        .mem_done_i(done), .mem_buf_idx_i(bidx), .mem_buf_data_o(bdat), .mem_buf_tag_o());
    nec_mem_model nec_mem_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .op_i(op),
        .addr_i(maddr[7:0]), .wdata_i(mwd), .done_o(done), .rdata_o(mrd), .lock_o(lock));
    task finish_test; begin
        $display("checks %0d errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    end endtask
    // one access plus a gap cycle
    task wr(input [2:0] a, input [7:0] d); begin
        ra <= a; rw <= d; we <= 1'b1; @(posedge clk_i); we <= 1'b0; @(posedge clk_i);
    end endtask
    task rd(input [2:0] a, input [7:0] e); begin
        ra <= a; re <= 1'b1; @(posedge clk_i); re <= 1'b0; #1 `CHK("reg", e, rdat)
        @(posedge clk_i);
    end endtask
    // access held until taken; loads wait for data
    task dbg(input w, input [23:0] a, input [7:0] d, input [7:0] e); begin
        da <= a; dw <= d; dwe <= w; dre <= !w; k = 0;
        do begin @(posedge clk_i); k++; end while (!rdy && k < 200);
        dwe <= 1'b0; dre <= 1'b0;
        if (!w) do begin @(posedge clk_i); k++; end while (!rv && k < 200);
        if (k >= 200) begin n_fail++; finish_test; end
        if (!w) `CHK("load", e, drd)
    end endtask
    task idle; begin // polls interface enable
        k = 0;
        do begin @(posedge clk_i); k++; end while ((busy || req || !ifen) && k < 200);
        if (k >= 200) begin n_fail++; finish_test; end
    end endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 5; i++) begin
            wr(3'h0, {1'b0, RDC[7*i +: 7]});
            dbg(1'b0, 24'h000100 + i, 8'h00, 8'h5a ^ i[7:0]);
        end
        // empty checksum stream leaves the seed
        wr(3'h0, 8'h39); wr(3'h1, 8'h01); #1 `CHK("busy", 1'b1, busy)
        idle; rd(3'h3, 8'hff); rd(3'h4, 8'hff);
        // low byte held, high byte commits
        wr(3'h0, 8'h23); dbg(1'b1, 24'h000004, 8'h11, 8'h00); idle;
        dbg(1'b1, 24'h000005, 8'h22, 8'h00); #1 `CHK("ready", 1'b0, rdy)
        bidx <= 7'h02; idle; #1 `CHK("word", 16'h2211, bdat)
        for (int i = 0; i < 10; i++) begin
            wr(3'h0, {1'b0, WRC[7*i +: 7]}); dbg(1'b1, 24'h000085, 8'h00, 8'h00);
            #1 `CHK("busy", 1'b1, busy)
            `CHK("op", WRC[7*i +: 7], op)
            idle;
        end
        wr(3'h0, 8'h33); dbg(1'b1, 24'h000003, 8'h77, 8'h00); #1 `CHK("busy", 1'b0, busy)
        idle; wr(3'h0, 8'h36); wr(3'h1, 8'h01); `CHK("busy", 1'b1, busy)
        // full lock: only erase and flash checksum run
        wr(3'h3, 8'hfc); wr(3'h0, 8'h08); wr(3'h1, 8'h01); idle; rd(3'h6, 8'hfc);
        wr(3'h0, 8'h07); dbg(1'b0, 24'h000010, 8'h00, 8'h00); idle;
        wr(3'h0, 8'h78); wr(3'h5, 8'h01); #1 `CHK("ifen", 1'b0, ifen)
        idle; wr(3'h0, 8'h40); wr(3'h1, 8'h01); idle; rd(3'h6, 8'hff);
        wr(3'h0, 8'h4c); dbg(1'b1, 24'h000010, 8'h0f, 8'h00); idle;
        `CHK("fuse", 8'h0a, mwd)
        wr(3'h0, 8'h00); wr(3'h1, 8'h01); #1 `CHK("busy", 1'b0, busy)
        rd(3'h2, 8'h02); rd(3'h7, 8'h00);
        finish_test;
    end
endmodule // tb_top

// ===== hdl/nec_crc.v
// nec_crc: 16-bit checksum engine fed one byte per strobe.
// assumes bytes arrive on the system clock.
`timescale 1ns/1ps
`include "nec_defs.vh"
module nec_crc (
    input  wire        clk_i,           // system clock
    input  wire        rst_b_i,         // sync reset, active low
    input  wire        ce_i,            // clock enable
    input  wire        clr_i,           // reload seed
    input  wire        en_i,            // take one byte
    input  wire [7:0]  byte_i,          // byte taken
    output reg  [15:0] crc_o            // running checksum
);
    reg [15:0] next_crc;
    integer    i;

    // msb-first, eight bits
    always @* begin
        next_crc = crc_o ^ {byte_i, 8'h00};
        for (i = 0; i < 8; i = i + 1) begin
            if (next_crc[15]) begin
                next_crc = {next_crc[14:0], 1'b0} ^ `NEC_CRC_POLY;
            end else begin
                next_crc = {next_crc[14:0], 1'b0};
            end
        end
    end

    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            crc_o <= `NEC_CRC_SEED;
        end else if (ce_i) begin
            if (clr_i) begin
                crc_o <= `NEC_CRC_SEED;
            end else if (en_i) begin
                crc_o <= next_crc;
            end
        end
    end
endmodule // nec_crc

// ===== hdl/nec_ctrl.v
// nec_ctrl: runs memory commands for an external programmer.
// assumes debug port, register port and array share clk_i;
// the array pulses mem_done_i when an op ends.
//
// Overview of operation
// [RULE_01] 0x39 checksums boot section
// [RULE_02] user row: 0x01 read, 0x18/0x1a erase/write
// [RULE_03] 0x02 reads production row
// [RULE_04] 0x4c writes fuse, 0x08 lock
// [RULE_05] 0x33 loads, 0x36 clears eeprom buffer
// [RULE_06] 0x32/0x34/0x35 eeprom page ops
// [RULE_07] section erases start by execute
// [RULE_08] 0x06 reads eeprom, 0x07 fuses
// [RULE_09] read code, then debug read
// [RULE_10] chip erase spares rows, fuses
// [RULE_11] load chip erase, then execute
// [RULE_12] erase, flash checksum drop interface
// [RULE_13] busy held until completion
// [RULE_14] low byte held, high commits
// [RULE_15] debug port halted after load
// [RULE_16] any byte addresses page
// [RULE_17] erase-then-write is atomic
// [RULE_18] checksum lands in data registers
// [RULE_19] flash checksum ignores lock
// [RULE_20] fuse, lock writes only secure
// [RULE_21] programmer unlocks interface first
// [RULE_22] execute, load, store triggers
// [RULE_23] full lock: erase, flash checksum only
// [RULE_24] reads blocked while busy
// [RULE_25] unknown codes start nothing
`timescale 1ns/1ps
`include "nec_defs.vh"
module nec_ctrl #(
    parameter FP_AW = 7,                // flash page buffer word index width
    parameter EP_AW = 5                 // eeprom page buffer byte index width
) (
    input  wire        clk_i,                // system clock
    input  wire        rst_b_i,              // synchronous reset, active low
    input  wire        ce_i,                 // clock enable, freezes all state
    input  wire [2:0]  reg_addr_i,           // offset
    input  wire [7:0]  reg_wdata_i,          // write data
    input  wire        reg_we_i,             // write strobe
    input  wire        reg_re_i,             // read strobe
    output reg  [7:0]  reg_rdata_o,          // read data
    input  wire [23:0] dbg_addr_i,           // byte address
    input  wire [7:0]  dbg_wdata_i,          // store data
    input  wire        dbg_we_i,             // store access
    input  wire        dbg_re_i,             // load access
    output reg         dbg_ready_o,          // access taken
    output reg  [7:0]  dbg_rdata_o,          // load data
    output reg         dbg_rvalid_o,         // load pulse
    output reg         interface_enabled_o,  // path enabled
    output reg         busy_o,               // busy
    input  wire        eeprom_preserve_fuse_i, // fuse set
    input  wire [7:0]  lock_bits_i,          // lock bits
    output reg         mem_req_o,            // op request
    output reg  [6:0]  mem_op_o,             // op code
    output reg  [23:0] mem_addr_o,           // byte address
    output reg  [7:0]  mem_wdata_o,          // fuse or lock
    output reg         mem_keep_eeprom_o,    // keep eeprom
    input  wire [7:0]  mem_rdata_i,          // read byte
    input  wire        mem_byte_valid_i,     // byte strobe
    input  wire [7:0]  mem_byte_i,           // checksum byte
    input  wire        mem_done_i,           // op done
    input  wire [FP_AW-1:0] mem_buf_idx_i,   // slot index
    output wire [15:0] mem_buf_data_o,       // slot data
    output wire        mem_buf_tag_o         // slot tag
);
    // command classes
    localparam K_NONE = 3'h0;
    localparam K_READ = 3'h1;
    localparam K_LDF  = 3'h2;
    localparam K_LDE  = 3'h3;
    localparam K_WMEM = 3'h4;
    localparam K_XMEM = 3'h5;
    localparam K_XBUF = 3'h6;
    localparam K_FUSE = 3'h7;

    // controller states
    localparam S_IDLE  = 3'h0;
    localparam S_MEM   = 3'h1;
    localparam S_RMWRD = 3'h2;
    localparam S_RMWGO = 3'h3;
    localparam S_CLR   = 3'h4;
    localparam S_HALT  = 3'h5;

    // section erases take both triggers
    function [2:0] wr_class;
        input [6:0] c;
        begin
            case (c)
                `NEC_C_LOAD_FBUF:  wr_class = K_LDF;
                `NEC_C_LOAD_EBUF:  wr_class = K_LDE;
                `NEC_C_WRITE_FUSE: wr_class = K_FUSE;
                `NEC_C_WRITE_LOCK, `NEC_C_ERASE_APP, `NEC_C_ERASE_BOOT,
                `NEC_C_ERASE_FPAGE, `NEC_C_WRITE_FPAGE, `NEC_C_EW_FPAGE,
                `NEC_C_ERASE_APAGE, `NEC_C_WRITE_APAGE, `NEC_C_EW_APAGE,
                `NEC_C_ERASE_BPAGE, `NEC_C_WRITE_BPAGE, `NEC_C_EW_BPAGE,
                `NEC_C_ERASE_USIG, `NEC_C_WRITE_USIG, `NEC_C_ERASE_EPAGE,
                `NEC_C_WRITE_EPAGE, `NEC_C_EW_EPAGE: wr_class = K_WMEM;
                default:           wr_class = K_NONE;
            endcase
        end
    endfunction

    function [2:0] rd_class;
        input [6:0] c;
        begin
            case (c)
                `NEC_C_READ_NVM, `NEC_C_READ_USIG, `NEC_C_READ_PSIG,
                `NEC_C_READ_FUSE, `NEC_C_READ_EE: rd_class = K_READ;
                default:           rd_class = K_NONE;
            endcase
        end
    endfunction

    function [2:0] ex_class;
        input [6:0] c;
        begin
            case (c)
                `NEC_C_ERASE_FBUF, `NEC_C_ERASE_EBUF: ex_class = K_XBUF;
                `NEC_C_CHIP_ERASE, `NEC_C_FLASH_CRC, `NEC_C_APP_CRC,
                `NEC_C_BOOT_CRC, `NEC_C_ERASE_EE, `NEC_C_ERASE_APP,
                `NEC_C_ERASE_BOOT, `NEC_C_WRITE_LOCK: ex_class = K_XMEM;
                default:           ex_class = K_NONE;
            endcase
        end
    endfunction

    reg  [6:0]  cmd;
    reg  [7:0]  data0;
    reg  [7:0]  data1;
    reg  [2:0]  state;
    reg  [7:0]  low_hold;
    reg  [7:0]  rmw_val;
    reg         op_crc;
    reg         fbuf_wr;
    reg         ebuf_wr;
    reg         buf_clr;
    reg         crc_clr;
    wire [15:0] crc_val;
    wire [15:0] fbuf_q;
    wire [7:0]  ebuf_q;
    wire        fbuf_tag;
    wire        ebuf_tag;
    reg         sel_ebuf;

    wire locked  = (lock_bits_i & `NEC_LOCK_RW_MASK) == `NEC_LOCK_RW_SET;
    wire allowed = !locked || cmd == `NEC_C_CHIP_ERASE
                   || cmd == `NEC_C_FLASH_CRC;                       // [RULE_23] [RULE_19]
    wire is_crc  = cmd == `NEC_C_FLASH_CRC || cmd == `NEC_C_APP_CRC
                   || cmd == `NEC_C_BOOT_CRC;
    wire is_disc = cmd == `NEC_C_CHIP_ERASE || cmd == `NEC_C_FLASH_CRC;
    wire exec_hit = reg_we_i && ((reg_addr_i == `NEC_REG_CTRL_A
                    && reg_wdata_i[`NEC_CTRL_EXECUTE_BIT])
                    || reg_addr_i == `NEC_REG_EXEC_ALIAS);
    wire dbg_take = dbg_ready_o && (dbg_we_i || dbg_re_i);
    wire is_ee_cmd = cmd == `NEC_C_ERASE_EPAGE || cmd == `NEC_C_WRITE_EPAGE
                     || cmd == `NEC_C_EW_EPAGE || cmd == `NEC_C_ERASE_EE;

    // flash words, eeprom bytes
    nec_pagebuf #(.W(16), .AW(FP_AW)) u_fbuf (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .ce_i     (ce_i),
        .wr_i     (fbuf_wr),
        .idx_i    (dbg_addr_i[FP_AW:1]),
        .wdata_i  ({dbg_wdata_i, low_hold}),
        .clr_i    (buf_clr && !sel_ebuf),
        .rd_idx_i (mem_buf_idx_i),
        .rdata_o  (fbuf_q),
        .rtag_o   (fbuf_tag)
    );

    nec_pagebuf #(.W(8), .AW(EP_AW)) u_ebuf (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .ce_i     (ce_i),
        .wr_i     (ebuf_wr),
        .idx_i    (dbg_addr_i[EP_AW-1:0]),
        .wdata_i  (dbg_wdata_i),
        .clr_i    (buf_clr && sel_ebuf),
        .rd_idx_i (mem_buf_idx_i[EP_AW-1:0]),
        .rdata_o  (ebuf_q),
        .rtag_o   (ebuf_tag)
    );

    nec_crc u_crc (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .clr_i   (crc_clr),
        .en_i    (op_crc && mem_byte_valid_i),
        .byte_i  (mem_byte_i),
        .crc_o   (crc_val)
    );

    // buffer ports are flops; this only selects
    assign mem_buf_data_o = sel_ebuf ? {8'h00, ebuf_q} : fbuf_q;
    assign mem_buf_tag_o  = sel_ebuf ? ebuf_tag : fbuf_tag;

    // buffer strobes from the taken store; checksum seed reload from execute
    always @* begin
        fbuf_wr = dbg_take && dbg_we_i && wr_class(cmd) == K_LDF
                  && allowed && dbg_addr_i[0];                      // [RULE_14]
        ebuf_wr = dbg_take && dbg_we_i && wr_class(cmd) == K_LDE
                  && allowed;                                       // [RULE_05]
        crc_clr = state == S_IDLE && exec_hit && is_crc && allowed;
    end

    // read data stand one cycle after the strobe
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (ce_i) begin
            reg_rdata_o <= 8'h00;
            if (reg_re_i) begin
                case (reg_addr_i)
                    `NEC_REG_CMD:    reg_rdata_o <= {1'b0, cmd};
                    `NEC_REG_STATUS: reg_rdata_o <= {6'h00, interface_enabled_o, busy_o};
                    `NEC_REG_DATA0:  reg_rdata_o <= data0;
                    `NEC_REG_DATA1:  reg_rdata_o <= data1;
                    `NEC_REG_LOCK:   reg_rdata_o <= lock_bits_i;
                    default:         reg_rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // checksum result beats a same-cycle write
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            cmd   <= `NEC_CMD_RESET;
            data0 <= `NEC_DATA_RESET;
            data1 <= `NEC_DATA_RESET;
        end else if (ce_i) begin
            if (reg_we_i && reg_addr_i == `NEC_REG_CMD && state == S_IDLE) begin
                cmd <= reg_wdata_i[6:0];
            end
            if (state == S_MEM && mem_done_i && op_crc) begin
                data0 <= crc_val[7:0];                              // [RULE_18]
                data1 <= crc_val[15:8];
            end else if (reg_we_i && reg_addr_i == `NEC_REG_DATA0) begin
                data0 <= reg_wdata_i;
            end else if (reg_we_i && reg_addr_i == `NEC_REG_DATA1) begin
                data1 <= reg_wdata_i;
            end
        end
    end

    // one command at a time; debug port waits on ready
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            state               <= S_IDLE;
            dbg_ready_o         <= 1'b1;
            dbg_rdata_o         <= 8'h00;
            dbg_rvalid_o        <= 1'b0;
            interface_enabled_o <= 1'b1;
            busy_o              <= 1'b0;
            mem_req_o           <= 1'b0;
            mem_op_o            <= `NEC_C_NOP;
            mem_addr_o          <= 24'h000000;
            mem_wdata_o         <= 8'h00;
            mem_keep_eeprom_o   <= 1'b0;
            low_hold            <= 8'h00;
            rmw_val             <= 8'h00;
            op_crc              <= 1'b0;
            buf_clr             <= 1'b0;
            sel_ebuf            <= 1'b0;
        end else if (ce_i) begin
            dbg_rvalid_o <= 1'b0;
            buf_clr      <= 1'b0;
            case (state)
                S_IDLE: begin
                    sel_ebuf <= is_ee_cmd || cmd == `NEC_C_ERASE_EBUF;
                    if (exec_hit && allowed && ex_class(cmd) != K_NONE) begin
                        busy_o      <= 1'b1;                        // [RULE_13] [RULE_22]
                        dbg_ready_o <= 1'b0;
                        if (ex_class(cmd) == K_XBUF) begin
                            buf_clr <= 1'b1;                        // [RULE_05]
                            state   <= S_CLR;
                        end else begin
                            mem_req_o   <= 1'b1;                    // [RULE_07] [RULE_01]
                            mem_op_o    <= cmd;
                            mem_wdata_o <= data0 & lock_bits_i;     // [RULE_20] [RULE_04]
                            mem_keep_eeprom_o <= cmd == `NEC_C_CHIP_ERASE
                                                 && eeprom_preserve_fuse_i; // [RULE_10]
                            op_crc      <= is_crc;
                            interface_enabled_o <= !is_disc;        // [RULE_12]
                            state       <= S_MEM;
                        end
                    end else if (dbg_take) begin
                        dbg_ready_o <= 1'b0;
                        mem_addr_o  <= dbg_addr_i;                  // [RULE_16]
                        mem_op_o    <= cmd;
                        if (dbg_re_i && rd_class(cmd) == K_READ && allowed) begin
                            mem_req_o <= 1'b1;                      // [RULE_08] [RULE_03] [RULE_02]
                            state     <= S_MEM;
                        end else if (dbg_we_i && allowed && wr_class(cmd) == K_WMEM) begin
                            busy_o      <= 1'b1;                    // [RULE_06] [RULE_17]
                            mem_req_o   <= 1'b1;
                            mem_wdata_o <= dbg_wdata_i & lock_bits_i; // [RULE_20]
                            state       <= S_MEM;
                        end else if (dbg_we_i && allowed && wr_class(cmd) == K_FUSE) begin
                            busy_o    <= 1'b1;                      // [RULE_04]
                            mem_req_o <= 1'b1;
                            mem_op_o  <= `NEC_C_READ_FUSE;
                            rmw_val   <= dbg_wdata_i;
                            state     <= S_RMWRD;
                        end else begin
                            if (dbg_we_i && wr_class(cmd) == K_LDF && !dbg_addr_i[0]) begin
                                low_hold <= dbg_wdata_i;            // [RULE_14]
                            end
                            dbg_rvalid_o <= dbg_re_i;               // [RULE_25]
                            dbg_rdata_o  <= 8'h00;
                            state        <= S_HALT;                 // [RULE_15]
                        end
                    end
                end
                S_MEM: begin
                    if (mem_done_i) begin
                        mem_req_o           <= 1'b0;
                        busy_o              <= 1'b0;                // [RULE_13]
                        interface_enabled_o <= 1'b1;
                        op_crc              <= 1'b0;
                        mem_keep_eeprom_o   <= 1'b0;
                        dbg_ready_o         <= 1'b1;                // [RULE_24]
                        if (rd_class(mem_op_o) == K_READ) begin
                            dbg_rdata_o  <= mem_rdata_i;            // [RULE_09]
                            dbg_rvalid_o <= 1'b1;
                        end
                        state <= S_IDLE;
                    end
                end
                S_RMWRD: begin
                    // fuse bits only go from one to zero
                    if (mem_done_i) begin
                        mem_req_o   <= 1'b0;
                        mem_wdata_o <= rmw_val & mem_rdata_i;       // [RULE_20]
                        state       <= S_RMWGO;
                    end
                end
                S_RMWGO: begin
                    mem_req_o <= 1'b1;
                    mem_op_o  <= `NEC_C_WRITE_FUSE;
                    state     <= S_MEM;
                end
                S_CLR: begin
                    busy_o      <= 1'b0;
                    dbg_ready_o <= 1'b1;
                    state       <= S_IDLE;
                end
                S_HALT: begin
                    dbg_ready_o <= 1'b1;
                    state       <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // nec_ctrl

// ===== hdl/nec_defs.vh
// nec_defs.vh: codes, offsets, fields and reset values of the command controller.
// assumes inclusion by bare name.
`ifndef NEC_DEFS_VH
`define NEC_DEFS_VH

// register offsets
`define NEC_REG_CMD        3'h0
`define NEC_REG_CTRL_A     3'h1
`define NEC_REG_STATUS     3'h2
`define NEC_REG_DATA0      3'h3
`define NEC_REG_DATA1      3'h4
`define NEC_REG_EXEC_ALIAS 3'h5
`define NEC_REG_LOCK       3'h6

// field positions
`define NEC_CTRL_EXECUTE_BIT  0

// reset values and checksum polynomial
`define NEC_CMD_RESET   7'h00
`define NEC_DATA_RESET  8'h00
`define NEC_CRC_SEED    16'hffff
`define NEC_CRC_POLY    16'h1021

// full lock: both lock bits programmed (zero)
`define NEC_LOCK_RW_MASK 8'h03
`define NEC_LOCK_RW_SET  8'h00

// command codes
`define NEC_C_NOP          7'h00
`define NEC_C_CHIP_ERASE   7'h40
`define NEC_C_READ_NVM     7'h43
`define NEC_C_LOAD_FBUF    7'h23
`define NEC_C_ERASE_FBUF   7'h26
`define NEC_C_ERASE_FPAGE  7'h2b
`define NEC_C_WRITE_FPAGE  7'h2e
`define NEC_C_EW_FPAGE     7'h2f
`define NEC_C_FLASH_CRC    7'h78
`define NEC_C_ERASE_APP    7'h20
`define NEC_C_ERASE_APAGE  7'h22
`define NEC_C_WRITE_APAGE  7'h24
`define NEC_C_EW_APAGE     7'h25
`define NEC_C_APP_CRC      7'h38
`define NEC_C_ERASE_BOOT   7'h68
`define NEC_C_ERASE_BPAGE  7'h2a
`define NEC_C_WRITE_BPAGE  7'h2c
`define NEC_C_EW_BPAGE     7'h2d
`define NEC_C_BOOT_CRC     7'h39
`define NEC_C_READ_USIG    7'h01
`define NEC_C_ERASE_USIG   7'h18
`define NEC_C_WRITE_USIG   7'h1a
`define NEC_C_READ_PSIG    7'h02
`define NEC_C_READ_FUSE    7'h07
`define NEC_C_WRITE_FUSE   7'h4c
`define NEC_C_WRITE_LOCK   7'h08
`define NEC_C_LOAD_EBUF    7'h33
`define NEC_C_ERASE_EBUF   7'h36
`define NEC_C_ERASE_EE     7'h30
`define NEC_C_ERASE_EPAGE  7'h32
`define NEC_C_WRITE_EPAGE  7'h34
`define NEC_C_EW_EPAGE     7'h35
`define NEC_C_READ_EE      7'h06

`endif

// ===== hdl/nec_pagebuf.v
// nec_pagebuf: tagged page buffer with a registered read port.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module nec_pagebuf #(
    parameter W  = 16,                  // slot width
    parameter AW = 7                    // slot index width
) (
    input  wire          clk_i,         // system clock
    input  wire          rst_b_i,       // sync reset, active low
    input  wire          ce_i,          // clock enable
    input  wire          wr_i,          // write one slot and tag it
    input  wire [AW-1:0] idx_i,         // slot written
    input  wire [W-1:0]  wdata_i,       // data written
    input  wire          clr_i,         // erase whole buffer
    input  wire [AW-1:0] rd_idx_i,      // slot read
    output reg  [W-1:0]  rdata_o,       // slot data, one cycle later
    output reg           rtag_o         // slot tag, one cycle later
);
    localparam D = 1 << AW;

    reg [W-1:0] mem [0:D-1];
    reg [D-1:0] tag;

    // data array carries no reset; the tags decide what is valid
    always @(posedge clk_i) begin
        if (ce_i && wr_i) begin
            mem[idx_i] <= wdata_i;
        end
    end

    // tags and registered read
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            tag     <= {D{1'b0}};
            rdata_o <= {W{1'b0}};
            rtag_o  <= 1'b0;
        end else if (ce_i) begin
            if (clr_i) begin
                tag <= {D{1'b0}};
            end else if (wr_i) begin
                tag[idx_i] <= 1'b1;
            end
            rdata_o <= tag[rd_idx_i] ? mem[rd_idx_i] : {W{1'b1}};
            rtag_o  <= tag[rd_idx_i];
        end
    end
endmodule // nec_pagebuf
